// ==== ctrl_src_pkg.sv ====
package ctrl_src_pkg;

   // ----------------------------------------------------------------
   // Register map (word offsets on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_SETTING = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;

   // ----------------------------------------------------------------
   // Setting register fields
   // ----------------------------------------------------------------
   localparam int BIT_LOCAL_HMI = 0;
   localparam int BIT_REMOTE_HMI = 1;
   localparam int BIT_REMOTE_TERM = 2;
   localparam int BIT_THREE_WIRE = 3;
   localparam int BIT_BUMPLESS = 4;
   localparam int BIT_DIRECT = 5;
   localparam int BIT_TERM_STOP_INH = 6;
   localparam int BIT_PANEL_STOP_INH = 7;
   localparam int BIT_OVERLOAD = 8;
   localparam int SETTING_W = 9;
   localparam logic [SETTING_W-1:0] SETTING_RST = 9'h000;

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int STAT_CHAN_LO = 0;
   localparam int STAT_REMOTE = 2;
   localparam int STAT_FALLBACK = 3;
   localparam int STAT_OUT1 = 4;
   localparam int STAT_OUT2 = 5;
   localparam int STAT_HOLD = 6;

   typedef enum logic [1:0] {
      CHAN_TERM = 2'h0,
      CHAN_PANEL = 2'h1,
      CHAN_NET = 2'h2
   } chan_type;

   // One command channel: run forward, run reverse, stop, comm good
   typedef struct packed {
      logic run1;
      logic run2;
      logic stop;
      logic link_ok;
   } cmd_type;

endpackage

// ==== cmd_filter.sv ====
`timescale 1ns/1ps
// Reduces one channel's request to accepted run/stop under wiring mode
module cmd_filter (
   input wire logic i_active,
   input wire logic i_three_wire,
   input wire logic i_stop_inh,
   input wire ctrl_src_pkg::cmd_type i_cmd,
   output logic o_run1,
   output logic o_run2,
   output logic o_stop,
   output logic o_level
);
   wire run_ok = i_active;
   wire stop_ok = i_active && !(i_three_wire && i_stop_inh);
   assign o_run1 = run_ok && i_cmd.run1;
   assign o_run2 = run_ok && i_cmd.run2;
   assign o_stop = stop_ok && i_cmd.stop;
   // 2-wire: outputs follow run levels; 3-wire: run pulses latch
   assign o_level = !i_three_wire;
endmodule

// ==== control_source_selector.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Exactly one commanding channel among terminal, panel and network.
// - Local source uses terminal or panel per setting; never network.
// - Remote source is network unless operator unit present, then setting chooses.
// - Selector inactive gives local; active follows unit, remote if unit absent.
// - Network commands always use 2-wire semantics.
// - In 3-wire mode stop can be inhibited for terminal and panel.
// - In 2-wire mode stops from non-commanding channels are ignored.
// - Run commands from non-commanding channels are ignored.
// - Only one source drives the outputs at a time.
// - Terminal commanding: terminal start/stop drive outputs, others ignored.
// - Panel commanding: panel start/stop drive outputs, others ignored.
// - Network commanding: network drives outputs; panel writes rejected.
// - Bump transfer opens both outputs until next valid command, except overload.
// - Bumpless transfer keeps outputs until next valid command.
// - Remote to local: bump stops, 3-wire bumpless runs, 2-wire needs run input.
// - Local to remote leaves motor unchanged, then follows the remote channel's commands.
// - Enter fallback on loss of commanding link, leave on restore.
// - Fallback entry is bumpless when direct-transition bit is set.
// - Fallback exit uses transfer mode together with direct-transition bit.
// - Transfer-mode bit set selects bumpless, clear selects bump.
// - Terminal is default commanding channel after reset with selector inactive.
module control_source_selector (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_selector,
   input wire logic i_unit_present,
   input wire logic i_unit_remote,
   input wire ctrl_src_pkg::cmd_type i_term_cmd,
   input wire ctrl_src_pkg::cmd_type i_panel_cmd,
   input wire ctrl_src_pkg::cmd_type i_net_cmd,
   input wire logic i_panel_wr_req,
   output logic o_panel_wr_ok,
   output logic o_out1,
   output logic o_out2
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int SYNC_W = 15;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   wire [SYNC_W-1:0] pins = {i_selector, i_unit_present, i_unit_remote,
                             i_term_cmd, i_panel_cmd, i_net_cmd};
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end
   wire sel_s = sync2_r[14];
   wire unit_s = sync2_r[13];
   wire unit_rem_s = sync2_r[12];
   ctrl_src_pkg::cmd_type term_s;
   ctrl_src_pkg::cmd_type panel_s;
   ctrl_src_pkg::cmd_type net_s;
   assign term_s = sync2_r[11:8];
   assign panel_s = sync2_r[7:4];
   assign net_s = sync2_r[3:0];

   // ----------------------------------------------------------------
   // Setting register
   // ----------------------------------------------------------------
   logic [ctrl_src_pkg::SETTING_W-1:0] setting_r;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         setting_r <= ctrl_src_pkg::SETTING_RST;
      end else if (i_wr && i_addr == ctrl_src_pkg::ADDR_SETTING) begin
         setting_r <= i_wdata[ctrl_src_pkg::SETTING_W-1:0];
      end
   end
   wire bumpless = setting_r[ctrl_src_pkg::BIT_BUMPLESS];
   wire direct = setting_r[ctrl_src_pkg::BIT_DIRECT];
   wire three_wire = setting_r[ctrl_src_pkg::BIT_THREE_WIRE];
   wire overload = setting_r[ctrl_src_pkg::BIT_OVERLOAD];

   // ----------------------------------------------------------------
   // Source and channel resolution
   // ----------------------------------------------------------------
   wire remote = sel_s && unit_s && unit_rem_s || sel_s && !unit_s;
   ctrl_src_pkg::chan_type local_chan;
   ctrl_src_pkg::chan_type remote_chan;
   ctrl_src_pkg::chan_type chan;
   assign local_chan = setting_r[ctrl_src_pkg::BIT_LOCAL_HMI] ?
      ctrl_src_pkg::CHAN_PANEL : ctrl_src_pkg::CHAN_TERM;
   assign remote_chan = !unit_s ? ctrl_src_pkg::CHAN_NET :
      setting_r[ctrl_src_pkg::BIT_REMOTE_TERM] ? ctrl_src_pkg::CHAN_TERM :
      setting_r[ctrl_src_pkg::BIT_REMOTE_HMI] ? ctrl_src_pkg::CHAN_PANEL :
      ctrl_src_pkg::CHAN_NET;
   assign chan = remote ? remote_chan : local_chan;

   // Panel writes are refused while the network commands
   assign o_panel_wr_ok = i_panel_wr_req && chan != ctrl_src_pkg::CHAN_NET;

   // ----------------------------------------------------------------
   // Per-channel command filters
   // ----------------------------------------------------------------
   logic [2:0] f_run1;
   logic [2:0] f_run2;
   logic [2:0] f_stop;
   logic [2:0] f_level;
   wire [2:0] act = {chan == ctrl_src_pkg::CHAN_NET,
                     chan == ctrl_src_pkg::CHAN_PANEL,
                     chan == ctrl_src_pkg::CHAN_TERM};
   cmd_filter u_term (
      .i_active(act[0]),
      .i_three_wire(three_wire),
      .i_stop_inh(setting_r[ctrl_src_pkg::BIT_TERM_STOP_INH]),
      .i_cmd(term_s),
      .o_run1(f_run1[0]),
      .o_run2(f_run2[0]),
      .o_stop(f_stop[0]),
      .o_level(f_level[0])
   );
   cmd_filter u_panel (
      .i_active(act[1]),
      .i_three_wire(three_wire),
      .i_stop_inh(setting_r[ctrl_src_pkg::BIT_PANEL_STOP_INH]),
      .i_cmd(panel_s),
      .o_run1(f_run1[1]),
      .o_run2(f_run2[1]),
      .o_stop(f_stop[1]),
      .o_level(f_level[1])
   );
   cmd_filter u_net (
      .i_active(act[2]),
      .i_three_wire(1'b0),
      .i_stop_inh(1'b0),
      .i_cmd(net_s),
      .o_run1(f_run1[2]),
      .o_run2(f_run2[2]),
      .o_stop(f_stop[2]),
      .o_level(f_level[2])
   );

   wire run1 = |f_run1;
   wire run2 = |f_run2;
   wire stop = |f_stop;
   wire level = |(f_level & act);
   wire link_ok = chan == ctrl_src_pkg::CHAN_NET ? net_s.link_ok :
                  chan == ctrl_src_pkg::CHAN_PANEL ? panel_s.link_ok : 1'b1;

   // ----------------------------------------------------------------
   // Transfer detection
   // ----------------------------------------------------------------
   ctrl_src_pkg::chan_type chan_r;
   logic remote_r;
   logic fallback_r;
   logic hold_r;
   logic out1_r;
   logic out2_r;
   wire chan_chg = chan != chan_r;
   wire to_local = remote_r && !remote;
   // Remote-to-local is a transfer even when the channel stays the same
   wire src_chg = chan_chg || to_local;
   wire fb_enter = !fallback_r && !link_ok;
   wire fb_exit = fallback_r && link_ok;
   // Fallback entry with direct bit is bumpless; otherwise per transfer mode
   wire enter_bump = !(direct || bumpless);
   // Exit bump only when both settings ask for it
   wire exit_bump = !bumpless && !direct;
   // Remote-to-local in 2-wire bumpless drops unless a run input is held
   wire rl_drop = to_local && bumpless && level && !(run1 || run2);
   wire bump_evt = !overload && (
      (src_chg && !bumpless && !(remote && !remote_r)) ||
      (fb_enter && enter_bump) || (fb_exit && exit_bump) || rl_drop);
   wire valid_cmd = run1 || run2 || stop;

   // ----------------------------------------------------------------
   // Output state
   // ----------------------------------------------------------------
   wire lvl_out1 = run1 && !stop;
   wire lvl_out2 = run2 && !stop && !run1;
   wire cmd_o1_nxt = level ? lvl_out1 : (stop ? 1'b0 : (run1 ? 1'b1 : out1_r));
   wire cmd_o2_nxt = level ? lvl_out2 :
                     (stop ? 1'b0 : (run2 && !run1 ? 1'b1 : (run1 ? 1'b0 : out2_r)));
   wire hold_nxt = src_chg ? 1'b1 : (valid_cmd ? 1'b0 : hold_r);
   // Hold applies on the transfer cycle itself, else 2-wire levels drop early
   wire holding = (hold_r || src_chg) && !valid_cmd;
   wire out1_nxt = bump_evt ? 1'b0 : (holding ? out1_r : cmd_o1_nxt);
   wire out2_nxt = bump_evt ? 1'b0 : (holding ? out2_r : cmd_o2_nxt);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         chan_r <= ctrl_src_pkg::CHAN_TERM;
         remote_r <= 1'b0;
         fallback_r <= 1'b0;
         hold_r <= 1'b0;
         out1_r <= 1'b0;
         out2_r <= 1'b0;
      end else begin
         chan_r <= chan;
         remote_r <= remote;
         fallback_r <= fb_enter ? 1'b1 : (fb_exit ? 1'b0 : fallback_r);
         hold_r <= hold_nxt;
         out1_r <= out1_nxt;
         out2_r <= out2_nxt;
      end
   end
   assign o_out1 = out1_r;
   assign o_out2 = out2_r;

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   wire [15:0] status = {9'h000, hold_r, out2_r, out1_r, fallback_r, remote_r,
                         chan_r};
   wire [15:0] rd_sel = i_addr == ctrl_src_pkg::ADDR_SETTING ?
                        {7'h00, setting_r} :
                        (i_addr == ctrl_src_pkg::ADDR_STATUS ? status : 16'h0000);
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= i_rd ? rd_sel : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   never_net_local_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !remote |-> chan != ctrl_src_pkg::CHAN_NET) else $error("network local");
   remote_net_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      remote && !unit_s |-> chan == ctrl_src_pkg::CHAN_NET) else $error("remote chan");
   one_hot_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $onehot(act)) else $error("channel not unique");
   ignore_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !act[2] |-> !f_run1[2] && !f_run2[2]) else $error("foreign run");
   panel_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[2] |-> !o_panel_wr_ok) else $error("panel write taken");
   bump_open_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      bump_evt |=> !o_out1 && !o_out2) else $error("bump kept outputs");
   bumpless_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      chan_chg && bumpless && !valid_cmd && !fb_enter && !fb_exit && !rl_drop
      |=> o_out1 == $past(out1_r) && o_out2 == $past(out2_r))
      else $error("bumpless changed outputs");
   fallback_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !link_ok |=> fallback_r) else $error("no fallback");
   net_two_wire_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[2] |-> level) else $error("network not 2-wire");

   // ----------------------------------------------------------------
   // Transfer checks
   // ----------------------------------------------------------------
   bump_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      src_chg && !bumpless && !overload && !(remote && !remote_r) |-> bump_evt)
      else $error("bump mode did not bump");
   bumpless_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      chan_chg && bumpless && !fb_enter && !fb_exit && !rl_drop |-> !bump_evt)
      else $error("bumpless mode bumped");
   to_remote_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      remote && !remote_r && !fb_enter && !fb_exit |-> !bump_evt)
      else $error("local to remote bumped");
   fb_direct_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      fb_enter && direct && !src_chg |-> !bump_evt)
      else $error("direct fallback entry bumped");
   fb_exit_bump_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      fb_exit && !bumpless && !direct && !overload |-> bump_evt)
      else $error("fallback exit did not bump");
   fb_exit_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      fb_exit && (bumpless || direct) && !src_chg |-> !bump_evt)
      else $error("fallback exit bumped");
   overload_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      overload |-> !bump_evt)
      else $error("overload mode bumped");
   hold_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      src_chg |=> hold_r)
      else $error("hold not set on transfer");
   hold_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      hold_r && !valid_cmd && !bump_evt |=> o_out1 == $past(out1_r) && o_out2 == $past(out2_r))
      else $error("held outputs moved");
   rl_two_wire_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      rl_drop && !overload |=> !o_out1 && !o_out2)
      else $error("2-wire transfer kept outputs");
   rl_three_wire_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      to_local && bumpless && !level && !valid_cmd && !fb_enter && !fb_exit
      |=> o_out1 == $past(out1_r) && o_out2 == $past(out2_r))
      else $error("3-wire transfer stopped motor");
   rl_bump_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      to_local && !bumpless && !overload |=> !o_out1 && !o_out2)
      else $error("remote to local bump kept outputs");

   // ----------------------------------------------------------------
   // Source resolution checks
   // ----------------------------------------------------------------
   local_term_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !remote && !setting_r[ctrl_src_pkg::BIT_LOCAL_HMI] |-> chan == ctrl_src_pkg::CHAN_TERM)
      else $error("local terminal not chosen");
   local_panel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !remote && setting_r[ctrl_src_pkg::BIT_LOCAL_HMI] |-> chan == ctrl_src_pkg::CHAN_PANEL)
      else $error("local panel not chosen");
   sel_local_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !sel_s |-> !remote)
      else $error("selector off gave remote");
   unit_local_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      sel_s && unit_s && !unit_rem_s |-> !remote)
      else $error("unit local gave remote");
   unit_remote_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      sel_s && (!unit_s || unit_rem_s) |-> remote)
      else $error("remote not taken");
   remote_term_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      remote && unit_s && setting_r[ctrl_src_pkg::BIT_REMOTE_TERM]
      |-> chan == ctrl_src_pkg::CHAN_TERM) else $error("remote terminal not chosen");

   // ----------------------------------------------------------------
   // Command filter checks
   // ----------------------------------------------------------------
   term_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !act[0] |-> !f_stop[0])
      else $error("foreign terminal stop");
   panel_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !act[1] |-> !f_stop[1])
      else $error("foreign panel stop");
   net_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !act[2] |-> !f_stop[2])
      else $error("foreign network stop");
   term_inhibit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[0] && three_wire && setting_r[ctrl_src_pkg::BIT_TERM_STOP_INH] |-> !f_stop[0])
      else $error("terminal stop not inhibited");
   panel_inhibit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[1] && three_wire && setting_r[ctrl_src_pkg::BIT_PANEL_STOP_INH] |-> !f_stop[1])
      else $error("panel stop not inhibited");
   term_only_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[0] |-> !f_run1[1] && !f_run2[1] && !f_run1[2] && !f_run2[2])
      else $error("start taken beside terminal");
   panel_only_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[1] |-> !f_run1[0] && !f_run2[0] && !f_run1[2] && !f_run2[2])
      else $error("start taken beside panel");
   net_stop_take_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      act[2] && net_s.stop |-> stop)
      else $error("network stop lost");
   panel_wr_pass_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !act[2] |-> o_panel_wr_ok == i_panel_wr_req)
      else $error("panel write wrongly refused");

   // ----------------------------------------------------------------
   // Fallback and timing checks
   // ----------------------------------------------------------------
   fb_leave_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      fb_exit |=> !fallback_r)
      else $error("fallback not left");
   chan_track_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> chan_r == $past(chan))
      else $error("channel history lags");
endmodule

// ==== cmd_partner.sv ====
`timescale 1ns/1ps
module cmd_partner (
   input wire logic i_clk_sys,
   input wire ctrl_src_pkg::cmd_type i_term_req,
   input wire ctrl_src_pkg::cmd_type i_panel_req,
   input wire ctrl_src_pkg::cmd_type i_net_req,
   output ctrl_src_pkg::cmd_type o_term_cmd,
   output ctrl_src_pkg::cmd_type o_panel_cmd,
   output ctrl_src_pkg::cmd_type o_net_cmd
);
   // ----------------------------------------------------------------
   // Far-side devices: levels change just after an edge
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      // Hard wiring has no link that can drop
      o_term_cmd <= {i_term_req[3:1], 1'b1};
      o_panel_cmd <= i_panel_req;
      o_net_cmd <= i_net_req;
   end
endmodule

// ==== control_source_selector_tb_top.sv ====
`timescale 1ns/1ps
module control_source_selector_tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sel = 1'b0;
   logic upres = 1'b0;
   logic urem = 1'b0;
   logic pwr = 1'b0;
   logic [15:0] rdata;
   logic pok;
   logic out1;
   logic out2;
   logic [15:0] r;
   ctrl_src_pkg::cmd_type tq = 4'h1;
   ctrl_src_pkg::cmd_type pq = 4'h1;
   ctrl_src_pkg::cmd_type nq = 4'h1;
   ctrl_src_pkg::cmd_type tc;
   ctrl_src_pkg::cmd_type pc;
   ctrl_src_pkg::cmd_type nc;
   int n_fail = 0;
   int checked = 0;
   logic [15:0] sv[5] = '{16'h0018, 16'h0008, 16'h0108, 16'h0010, 16'h0010};
   logic [3:0] tv[5] = '{4'h1, 4'h1, 4'h1, 4'h9, 4'h1};
   logic [1:0] ev[5] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h0};

   cmd_partner far (.i_clk_sys(clk_sys), .i_term_req(tq), .i_panel_req(pq), .i_net_req(nq),
      .o_term_cmd(tc), .o_panel_cmd(pc), .o_net_cmd(nc));
   control_source_selector uut (.i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_selector(sel),
      .i_unit_present(upres), .i_unit_remote(urem), .i_term_cmd(tc), .i_panel_cmd(pc),
      .i_net_cmd(nc), .i_panel_wr_req(pwr), .o_panel_wr_ok(pok), .o_out1(out1), .o_out2(out2));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Shared bus, stimulus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   // Low 4 status bits: fallback, remote, channel
   task automatic st(input logic [3:0] e);
      rreg(ctrl_src_pkg::ADDR_STATUS);
      chk(r[3:0], e);
   endtask
   // Six cycles cover partner, two sync stages and the output register
   task automatic go(input logic [3:0] t, p, n, input logic [2:0] s, input logic [1:0] e);
      @(posedge clk_sys);
      tq <= ctrl_src_pkg::cmd_type'(t);
      pq <= ctrl_src_pkg::cmd_type'(p);
      nq <= ctrl_src_pkg::cmd_type'(n);
      {sel, upres, urem} <= s;
      repeat (6) @(posedge clk_sys);
      #1 chk({out2, out1}, e);
   endtask
   task automatic pk(input logic e);
      @(posedge clk_sys);
      pwr <= 1'b1;
      #1 chk(pok, e);
      @(posedge clk_sys);
      pwr <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rreg(ctrl_src_pkg::ADDR_SETTING);
      chk(r, {7'h00, ctrl_src_pkg::SETTING_RST});
      st(4'h0);
      rreg(4'hf);
      chk(r, 16'h0000);
      wreg(ctrl_src_pkg::ADDR_STATUS, 16'hffff);
      rreg(ctrl_src_pkg::ADDR_SETTING);
      chk(r, 16'h0000);
   endtask
   task automatic t_local();
      go(4'h9, 4'h9, 4'h9, 3'h0, 2'h1);
      go(4'h9, 4'h3, 4'h3, 3'h0, 2'h1);
      go(4'h1, 4'h9, 4'h9, 3'h0, 2'h0);
      go(4'h5, 4'h1, 4'h1, 3'h0, 2'h2);
      go(4'hb, 4'h1, 4'h1, 3'h0, 2'h0);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0001);
      go(4'h1, 4'h9, 4'h1, 3'h0, 2'h1);
      st(4'h1);
      pk(1'b1);
      go(4'h9, 4'h1, 4'h9, 3'h0, 2'h0);
      go(4'h1, 4'h9, 4'h9, 3'h0, 2'h1);
      go(4'h1, 4'h9, 4'h9, 3'h4, 2'h1);
      st(4'h6);
      pk(1'b0);
      go(4'h1, 4'h1, 4'h5, 3'h4, 2'h2);
   endtask
   task automatic t_unit();
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0004);
      go(4'h1, 4'h1, 4'h1, 3'h6, 2'h0);
      st(4'h0);
      go(4'h1, 4'h1, 4'h1, 3'h7, 2'h0);
      st(4'h4);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h000c);
      go(4'h9, 4'h1, 4'h1, 3'h7, 2'h1);
      go(4'h1, 4'h1, 4'h1, 3'h7, 2'h1);
      go(4'h1, 4'h1, 4'h1, 3'h6, 2'h0);
      go(4'h1, 4'h1, 4'h1, 3'h7, 2'h0);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0002);
      st(4'h5);
      go(4'h1, 4'h1, 4'h1, 3'h4, 2'h0);
      st(4'h6);
   endtask
   task automatic t_wire3();
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0008);
      go(4'h1, 4'h1, 4'h9, 3'h4, 2'h1);
      go(4'h1, 4'h1, 4'h1, 3'h4, 2'h0);
      go(4'h9, 4'h1, 4'h1, 3'h0, 2'h1);
      go(4'h1, 4'h1, 4'h1, 3'h0, 2'h1);
      go(4'h3, 4'h1, 4'h1, 3'h0, 2'h0);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0048);
      go(4'h9, 4'h1, 4'h1, 3'h0, 2'h1);
      go(4'h3, 4'h1, 4'h1, 3'h0, 2'h1);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0008);
      go(4'h3, 4'h1, 4'h1, 3'h0, 2'h0);
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0089);
      go(4'h1, 4'h9, 4'h1, 3'h0, 2'h1);
      go(4'h1, 4'h3, 4'h1, 3'h0, 2'h1);
   endtask
   task automatic t_xfer();
      for (int i = 0; i < 5; i++) begin
         wreg(ctrl_src_pkg::ADDR_SETTING, sv[i]);
         go(4'h1, 4'h1, 4'h9, 3'h4, 2'h1);
         go(tv[i], 4'h1, 4'h9, 3'h0, ev[i]);
      end
   endtask
   task automatic t_fall();
      wreg(ctrl_src_pkg::ADDR_SETTING, 16'h0020);
      go(4'h1, 4'h1, 4'h9, 3'h4, 2'h1);
      go(4'h1, 4'h1, 4'h8, 3'h4, 2'h1);
      rreg(ctrl_src_pkg::ADDR_STATUS);
      chk(r[3], 1'b1);
      go(4'h1, 4'h1, 4'h9, 3'h4, 2'h1);
      rreg(ctrl_src_pkg::ADDR_STATUS);
      chk(r[3], 1'b0);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_local();
      t_unit();
      t_wire3();
      t_xfer();
      t_fall();
      print_verdict();
   end
endmodule
